// ### dv/cpu_side_model.sv
// cpu core and interrupt sources facing the wake block
// assumes the block's pclk; a taken vector clears the request behind it
`timescale 1ns/1ps
`include "wake_recovery_defs.svh"
module cpu_side_model (
    input wire logic pclk,
    input wire logic vector_load,
    output logic wait_enter,
    output logic stop_enter,
    output logic emulation_mode,
    output logic break_irq,
    output logic wdog_timeout,
    output logic irq_pin,
    output logic [7:0] kbd_pins,
    output logic [7:0] keyboard_polarity_bits,
    output logic [`PERIPH_COUNT-1:0] periph_irq,
    output logic tbm_rollover
);
    // quiet sources; key pin 0 armed for a rising edge
    initial begin
        {wait_enter, stop_enter, emulation_mode, break_irq} = 4'h0;
        {wdog_timeout, tbm_rollover, kbd_pins} = 10'h000;
        irq_pin = 1'b1;
        keyboard_polarity_bits = 8'h01;
        periph_irq = '0;
    end

    // the service routine clears its source; levels left up would re-wake
    always @(posedge pclk) begin
        if (vector_load === 1'b1) begin
            periph_irq <= '0;
            irq_pin <= 1'b1;
            break_irq <= 1'b0;
            emulation_mode <= 1'b0;
            kbd_pins <= 8'h00;
        end
    end

    // mode 0 wait, 1 stop, others stay awake; one-cycle request from run
    task automatic enter(input int mode);
        if (mode < 2) begin
            @(posedge pclk);
            wait_enter <= (mode == 0);
            stop_enter <= (mode == 1);
            @(posedge pclk);
            wait_enter <= 1'b0;
            stop_enter <= 1'b0;
        end
    endtask

    // 0..18 peripheral, 19 irq, 20 break, 21 watchdog, 22 key, 23 timebase
    task automatic fire(input int src);
        @(posedge pclk);
        case (src)
            19: irq_pin <= 1'b0;
            20: {emulation_mode, break_irq} <= 2'h3;
            21: wdog_timeout <= 1'b1;
            22: kbd_pins <= 8'h01;
            23: tbm_rollover <= 1'b1;
            default: periph_irq[src] <= 1'b1;
        endcase
        @(posedge pclk);
        wdog_timeout <= 1'b0;
        tbm_rollover <= 1'b0;
    endtask
endmodule

// ### dv/tb_top.sv
// self-checking bench for the wake, recovery and supply monitor block
// assumes the design, its checker and the cpu side model are compiled
`timescale 1ns/1ps
`include "wake_recovery_defs.svh"
module tb_top;
    localparam int LONG_REC = 40;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, ext_rst_n = 1'b1;
    logic below_fall_raw = 1'b0, above_rise_raw = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic pready, pslverr, e, reset_pin_o, reset_pin_oe, core_reset;
    logic vector_load, cpu_clk_en, sys_clk_en, monitor_enable;
    logic trip_high_select, osc_stop_keep, wait_enter, stop_enter;
    logic emulation_mode, break_irq, wdog_timeout, irq_pin, tbm_rollover;
    logic [7:0] kbd_pins, keyboard_polarity_bits;
    logic [`PERIPH_COUNT-1:0] periph_irq;
    logic [15:0] vector_addr;
    wire reset_pin;
    int err_count = 0, tests_run = 0, n;
    logic [15:0] vec [19] = '{16'hfff8, 16'hfff6, 16'hfff4, 16'hfff2,
        16'hfff0, 16'hffee, 16'hffec, 16'hffea, 16'hffe8, 16'hffe6,
        16'hffe4, 16'hffe2, 16'hffe0, 16'hffde, 16'hffdc, 16'hffd2,
        16'hffd0, 16'hffce, 16'hffcc};

    // open-drain reset pin with a pull-up behind the external driver
    assign reset_pin = (reset_pin_oe === 1'b1) ? reset_pin_o : ext_rst_n;
    always #5 pclk = ~pclk;

    wake_recovery_and_supply_monitor #(.RECOVERY_LONG(LONG_REC)) i_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .wait_enter, .stop_enter, .emulation_mode,
        .break_irq, .wdog_timeout, .irq_pin, .kbd_pins,
        .keyboard_polarity_bits, .periph_irq, .tbm_rollover,
        .below_fall_raw, .above_rise_raw, .reset_pin_i(reset_pin),
        .reset_pin_o, .reset_pin_oe, .core_reset, .vector_addr,
        .vector_load, .cpu_clk_en, .sys_clk_en, .monitor_enable,
        .trip_high_select, .osc_stop_keep);
    cpu_side_model i_core (
        .pclk, .vector_load, .wait_enter, .stop_enter, .emulation_mode,
        .break_irq, .wdog_timeout, .irq_pin, .kbd_pins,
        .keyboard_polarity_bits, .periph_irq, .tbm_rollover);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [15:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(q, exp);
    endtask
    // wait for the vector fetch, counting cycles, and compare the vector
    task automatic await(input logic [15:0] v);
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (vector_load !== 1'b1 && n < 300);
        check({15'h0, vector_load, vector_addr}, {16'h0001, v});
    endtask
    task automatic go(input int mode, input int src, input logic [15:0] v);
        i_core.enter(mode);
        i_core.fire(src);
        await(v);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // hang guard, well past the expected run length
    initial begin
        #200000;
        err_count++;
        tally_and_finish;
    end

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(16'hfe14, 32'h0001_fffe);
        rd(16'hfe0c, 32'h0000_0000);
        apb(1'b0, 16'hfe18, 32'h0000_0000);
        check({31'h0, e}, 32'h0000_0001);
        foreach (vec[i]) go(0, i, vec[i]);
        go(0, 19, 16'hfffa);
        go(0, 20, 16'hfffc);
        go(0, 21, 16'hfffe);
        i_core.enter(0);
        ext_rst_n <= 1'b0;
        repeat (4) @(posedge pclk);
        check({31'h0, core_reset}, 32'h0000_0001);
        ext_rst_n <= 1'b1;
        await(16'hfffe);
        go(1, 19, 16'hfffa);
        check(n, LONG_REC + 1);
        // stop ignores peripherals, and timebase without the oscillator kept
        i_core.enter(1);
        i_core.fire(0);
        i_core.fire(23);
        repeat (8) @(posedge pclk);
        check({31'h0, cpu_clk_en}, 32'h0000_0000);
        check({31'h0, monitor_enable}, 32'h0000_0000);
        go(2, 22, 16'hffe0);
        apb(1'b1, 16'hfe10, 32'h0000_0030);
        go(1, 23, 16'hffdc);
        check(n, `RECOVERY_SHORT_CYC + 1);
        go(1, 20, 16'hfffc);
        // low supply wakes stop, holds reset and the pin until it recovers
        apb(1'b1, 16'hfe10, 32'h0000_0004);
        i_core.enter(1);
        below_fall_raw <= 1'b1;
        repeat (LONG_REC + 20) @(posedge pclk);
        check({reset_pin_oe, reset_pin}, 32'h0000_0002);
        below_fall_raw <= 1'b0;
        rd(16'hfe0c, 32'h0000_0080);
        check({31'h0, core_reset}, 32'h0000_0001);
        above_rise_raw <= 1'b1;
        await(16'hfffe);
        rd(16'hfe0c, 32'h0000_0000);
        // polled mode flags only
        apb(1'b1, 16'hfe10, 32'h0000_0002);
        {below_fall_raw, above_rise_raw} <= 2'b10;
        repeat (8) @(posedge pclk);
        check({31'h0, reset_pin_oe}, 32'h0000_0000);
        rd(16'hfe0c, 32'h0000_0080);
        apb(1'b1, 16'hfe10, 32'h0000_0001);
        {below_fall_raw, above_rise_raw} <= 2'b00;
        @(negedge pclk);
        check({31'h0, monitor_enable}, 32'h0000_0000);
        // raising the trip point with the supply below it resets at once
        apb(1'b1, 16'hfe10, 32'h0000_0008);
        repeat (8) @(posedge pclk);
        check({31'h0, reset_pin_oe}, 32'h0000_0001);
        above_rise_raw <= 1'b1;
        await(16'hfffe);
        @(posedge pclk) presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(16'hfe10, 32'h0000_0000);
        tally_and_finish;
    end
endmodule

// ### dv/wake_recovery_monitor.sv
// port-level checks for the wake, recovery and supply monitor block
// assumes it is bound into the design top; one clock, async low reset
`timescale 1ns/1ps
module wake_recovery_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [15:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic emulation_mode,
    input wire logic below_fall_raw,
    input wire logic above_rise_raw,
    input wire logic reset_pin_o,
    input wire logic reset_pin_oe,
    input wire logic core_reset,
    input wire logic [15:0] vector_addr,
    input wire logic vector_load,
    input wire logic cpu_clk_en,
    input wire logic sys_clk_en,
    input wire logic monitor_enable,
    input wire logic trip_high_select
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // vectors land only once the core runs again
    chk_load_runs: assert property (vector_load |-> cpu_clk_en)
        else $error("vector load while core clock is off");
    chk_load_pulse: assert property (vector_load |=> !vector_load)
        else $error("vector load longer than one cycle");
    // low-supply hold pulls the pin and the core down together
    chk_pin_drive: assert property (reset_pin_oe |->
        !reset_pin_o && core_reset)
        else $error("held reset not driven onto pin");
    chk_break_gate: assert property (vector_load &&
        vector_addr == 16'hfffc |-> $past(emulation_mode))
        else $error("break vector outside emulation");
    // core clock never runs while system clocks are gated
    chk_core_first: assert property (cpu_clk_en |-> sys_clk_en)
        else $error("core clock ahead of system clocks");
    chk_stop_gate: assert property ($fell(sys_clk_en) |->
        !cpu_clk_en)
        else $error("core clock alive in stop");
    chk_boot_mon: assert property (!$past(presetn) |->
        monitor_enable && !trip_high_select)
        else $error("monitor defaults wrong after reset");
    // hold needs a synced low supply or a trip raise
    chk_hold_cause: assert property ($rose(reset_pin_oe) |->
        trip_high_select || $past(below_fall_raw, 3) ||
        $past(below_fall_raw, 4))
        else $error("supply hold without cause");
    chk_hold_keep: assert property ($fell(reset_pin_oe) |->
        !monitor_enable || $past(above_rise_raw, 3) ||
        $past(above_rise_raw, 4))
        else $error("supply hold dropped below rising trip");
    chk_status_bits: assert property (psel && !penable &&
        paddr == 16'hfe0c |=> prdata[31:8] == 24'h00_0000 &&
        prdata[6:0] == 7'h00)
        else $error("status register spare bits set");

    cover property (vector_load && vector_addr == 16'hfffa);
    cover property ($rose(reset_pin_oe));
    cover property ($fell(sys_clk_en));
endmodule

bind wake_recovery_and_supply_monitor wake_recovery_monitor i_mon (
    .pclk, .presetn, .psel, .penable, .paddr, .prdata, .pslverr,
    .emulation_mode, .below_fall_raw, .above_rise_raw, .reset_pin_o,
    .reset_pin_oe, .core_reset, .vector_addr, .vector_load, .cpu_clk_en,
    .sys_clk_en, .monitor_enable, .trip_high_select
);

// ### logic/wake_recovery_and_supply_monitor.sv
// wake source vectoring, stop recovery gating and supply monitor control
// assumes all pins synchronous to pclk except the two comparator outputs;
// peripheral requests are levels, tbm_rollover is a one-cycle pulse
`timescale 1ns/1ps
`include "wake_recovery_defs.svh"

module wake_recovery_and_supply_monitor #(
    parameter int RECOVERY_LONG = `RECOVERY_LONG_CYC,
    parameter int RECOVERY_SHORT = `RECOVERY_SHORT_CYC,
    parameter int KBD_PINS = `KBD_PIN_COUNT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wait_enter,
    input wire logic stop_enter,
    input wire logic emulation_mode,
    input wire logic break_irq,
    input wire logic wdog_timeout,
    input wire logic irq_pin,
    input wire logic [KBD_PINS-1:0] kbd_pins,
    input wire logic [KBD_PINS-1:0] keyboard_polarity_bits,
    input wire logic [`PERIPH_COUNT-1:0] periph_irq,
    input wire logic tbm_rollover,
    input wire logic below_fall_raw,
    input wire logic above_rise_raw,
    input wire logic reset_pin_i,
    output logic reset_pin_o,
    output logic reset_pin_oe,
    output logic core_reset,
    output logic [15:0] vector_addr,
    output logic vector_load,
    output logic cpu_clk_en,
    output logic sys_clk_en,
    output logic monitor_enable,
    output logic trip_high_select,
    output logic osc_stop_keep
);

    localparam int CW = `RECOVERY_CNT_W;

    // refuse recovery counts the 12-bit counter cannot hold
    if (RECOVERY_LONG < 1 || RECOVERY_LONG > (1 << CW) ||
        RECOVERY_SHORT < 1 || RECOVERY_SHORT > RECOVERY_LONG ||
        KBD_PINS < 1) begin : bad_params
        $error("unsupported recovery count or keyboard width");
    end

    // peripheral vectors, lower index wins
    localparam logic [15:0] PERIPH_VEC [`PERIPH_COUNT] = '{
        `VEC_CLKGEN, `VEC_T1_CH0, `VEC_T1_CH1, `VEC_T1_OVF,
        `VEC_T2_CH0, `VEC_T2_CH1, `VEC_T2_OVF, `VEC_SPI_RX,
        `VEC_SPI_TX, `VEC_SCI_ERR, `VEC_SCI_RX, `VEC_SCI_TX,
        `VEC_KBD, `VEC_ADC, `VEC_TBM, `VEC_T2_CH2,
        `VEC_T2_CH3, `VEC_T2_CH4, `VEC_T2_CH5
    };

    wake_recovery_pkg::power_state_t state;
    logic [7:0] config_reg_one;
    logic below_meta;
    logic below_sync;
    logic above_meta;
    logic above_sync;
    logic low_supply_flag;
    logic lvi_hold;
    logic trip_prev;
    logic [`TRIP_SETTLE_CYC-1:0] trip_chk;
    logic irq_prev;
    logic irq_fall;
    logic [KBD_PINS-1:0] kbd_prev;
    logic [KBD_PINS-1:0] kbd_wake;
    logic periph_hit;
    logic [15:0] periph_sel;
    logic [15:0] pend_vec;
    logic pend_reset;
    logic [CW-1:0] rec_count;
    logic monitor_power_down;
    logic monitor_reset_disable;
    logic monitor_stop_enable;
    logic short_recovery_select;
    logic monitor_active;
    logic run_reset;
    logic stop_reset;
    logic apb_setup;
    logic apb_write;
    logic [31:0] next_prdata;
    logic next_pslverr;

    // configuration fields
    assign monitor_power_down = config_reg_one[`BIT_PWR_DOWN];
    assign monitor_reset_disable = config_reg_one[`BIT_RST_DISABLE];
    assign monitor_stop_enable = config_reg_one[`BIT_STOP_ENABLE];
    assign trip_high_select = config_reg_one[`BIT_TRIP_HIGH];
    assign short_recovery_select = config_reg_one[`BIT_SHORT_REC];
    assign osc_stop_keep = config_reg_one[`BIT_OSC_KEEP];

    // monitor runs unless powered down; in stop only if kept on
    assign monitor_active = !monitor_power_down &&
        (state != wake_recovery_pkg::ST_STOP || monitor_stop_enable); // see [R16] see [R18]
    assign monitor_enable = monitor_active;

    // zero wait state slave
    assign pready = 1'b1;
    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pwrite;

    // comparator outputs are asynchronous to pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            below_meta <= 1'b0;
            below_sync <= 1'b0;
            above_meta <= 1'b0;
            above_sync <= 1'b0;
        end else begin
            below_meta <= below_fall_raw; // see [R24]
            below_sync <= below_meta;
            above_meta <= above_rise_raw;
            above_sync <= above_meta;
        end
    end

    // configuration register; power-on clears trip select to 3-V
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_reg_one <= `CONFIG_RESET; // see [R16] see [R19]
        end else if (apb_write && paddr == `OFS_WAKE_CONFIG) begin
            config_reg_one <= pwdata[7:0];
        end
    end

    // flag keeps its value between the trip levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_supply_flag <= 1'b0;
        end else if (monitor_active) begin
            if (below_sync) begin
                low_supply_flag <= 1'b1; // see [R22]
            end else if (above_sync) begin
                low_supply_flag <= 1'b0;
            end
        end
    end

    // comparator needs a few cycles to follow a new trip select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trip_prev <= 1'b0;
            trip_chk <= '0;
        end else begin
            trip_prev <= trip_high_select;
            trip_chk <= {trip_chk[`TRIP_SETTLE_CYC-2:0],
                trip_high_select && !trip_prev};
        end
    end

    // low supply reset with hysteresis; set beats clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvi_hold <= 1'b0;
        end else if (monitor_active && !monitor_reset_disable &&
            (below_sync || (trip_chk[`TRIP_SETTLE_CYC-1] &&
            !above_sync))) begin
            lvi_hold <= 1'b1; // see [R17] see [R19]
        end else if (above_sync || monitor_power_down ||
            monitor_reset_disable) begin
            lvi_hold <= 1'b0; // see [R20]
        end
    end

    // low supply reset pulls the shared reset pin low
    assign reset_pin_o = 1'b0;
    assign reset_pin_oe = lvi_hold; // see [R21]

    // irq pin edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_prev <= 1'b1;
        end else begin
            irq_prev <= irq_pin;
        end
    end
    assign irq_fall = irq_prev && !irq_pin; // see [R2]

    // keyboard edge per pin, direction from its polarity bit
    for (genvar i = 0; i < KBD_PINS; i++) begin : g_kbd
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                kbd_prev[i] <= 1'b0;
            end else begin
                kbd_prev[i] <= kbd_pins[i];
            end
        end
        assign kbd_wake[i] = keyboard_polarity_bits[i] ?
            (kbd_pins[i] && !kbd_prev[i]) :
            (!kbd_pins[i] && kbd_prev[i]); // see [R11]
    end

    // fixed priority over the peripheral requests
    always_comb begin
        periph_hit = 1'b0;
        periph_sel = `VEC_RESET;
        for (int i = `PERIPH_COUNT - 1; i >= 0; i--) begin
            if (periph_irq[i]) begin
                periph_hit = 1'b1;
                periph_sel = PERIPH_VEC[i]; // see [R6] see [R7] see [R8]
            end
        end
    end
    // table entries above are checked too // see [R9] see [R10]

    // reset sources; watchdog is unclocked in stop
    assign run_reset = !reset_pin_i || lvi_hold || wdog_timeout; // see [R4]
    assign stop_reset = !reset_pin_i || lvi_hold; // see [R1] see [R5]

    // power state machine with the stop recovery counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= wake_recovery_pkg::ST_HOLD;
            vector_addr <= `VEC_RESET;
            vector_load <= 1'b0;
            pend_vec <= `VEC_RESET;
            pend_reset <= 1'b0;
            rec_count <= '0;
        end else begin
            vector_load <= 1'b0;
            case (state)
                wake_recovery_pkg::ST_RUN: begin
                    if (run_reset) begin
                        state <= wake_recovery_pkg::ST_HOLD;
                    end else if (stop_enter) begin
                        state <= wake_recovery_pkg::ST_STOP;
                    end else if (wait_enter) begin
                        state <= wake_recovery_pkg::ST_WAIT;
                    end
                end
                wake_recovery_pkg::ST_WAIT: begin
                    if (run_reset) begin
                        state <= wake_recovery_pkg::ST_HOLD; // see [R1]
                    end else if (emulation_mode && break_irq) begin
                        state <= wake_recovery_pkg::ST_RUN;
                        vector_addr <= `VEC_BREAK; // see [R3]
                        vector_load <= 1'b1;
                    end else if (irq_fall) begin
                        state <= wake_recovery_pkg::ST_RUN;
                        vector_addr <= `VEC_IRQ; // see [R2]
                        vector_load <= 1'b1;
                    end else if (periph_hit) begin
                        state <= wake_recovery_pkg::ST_RUN;
                        vector_addr <= periph_sel; // see [R6]
                        vector_load <= 1'b1;
                    end
                end
                wake_recovery_pkg::ST_STOP: begin
                    // short delay only safe with a running oscillator
                    rec_count <= short_recovery_select ?
                        CW'(RECOVERY_SHORT - 1) :
                        CW'(RECOVERY_LONG - 1); // see [R13] see [R14]
                    if (stop_reset) begin
                        state <= wake_recovery_pkg::ST_RECOVER;
                        pend_vec <= `VEC_RESET; // see [R5]
                        pend_reset <= 1'b1;
                    end else if (emulation_mode && break_irq) begin
                        state <= wake_recovery_pkg::ST_RECOVER;
                        pend_vec <= `VEC_BREAK; // see [R3]
                        pend_reset <= 1'b0;
                    end else if (irq_fall) begin
                        state <= wake_recovery_pkg::ST_RECOVER;
                        pend_vec <= `VEC_IRQ; // see [R11]
                        pend_reset <= 1'b0;
                    end else if (|kbd_wake) begin
                        state <= wake_recovery_pkg::ST_RECOVER;
                        pend_vec <= `VEC_KBD; // see [R11]
                        pend_reset <= 1'b0;
                    end else if (tbm_rollover && osc_stop_keep) begin
                        state <= wake_recovery_pkg::ST_RECOVER;
                        pend_vec <= `VEC_TBM; // see [R12] see [R23]
                        pend_reset <= 1'b0;
                    end
                end
                wake_recovery_pkg::ST_RECOVER: begin
                    if (rec_count != '0) begin
                        rec_count <= rec_count - 1'b1; // see [R13]
                    end else if (pend_reset) begin
                        state <= wake_recovery_pkg::ST_HOLD;
                    end else begin
                        state <= wake_recovery_pkg::ST_RUN;
                        vector_addr <= pend_vec;
                        vector_load <= 1'b1;
                    end
                end
                wake_recovery_pkg::ST_HOLD: begin
                    // released only when pin high and supply recovered
                    if (reset_pin_i && !lvi_hold) begin
                        state <= wake_recovery_pkg::ST_RUN;
                        vector_addr <= `VEC_RESET; // see [R1] see [R20]
                        vector_load <= 1'b1;
                    end
                end
                default: begin
                    state <= wake_recovery_pkg::ST_HOLD;
                end
            endcase
        end
    end

    // clock gates follow the state; core reset follows the state and the low supply hold
    assign cpu_clk_en = (state == wake_recovery_pkg::ST_RUN);
    assign sys_clk_en = (state != wake_recovery_pkg::ST_STOP) &&
        (state != wake_recovery_pkg::ST_RECOVER); // see [R13]
    assign core_reset = lvi_hold || (state == wake_recovery_pkg::ST_HOLD) ||
        (state == wake_recovery_pkg::ST_RECOVER && pend_reset);

    // read mux; unmapped addresses answer with an error
    always_comb begin
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        case (paddr)
            `OFS_SUPPLY_STATUS: begin
                next_prdata[`BIT_LOW_SUPPLY] = low_supply_flag; // see [R22]
            end
            `OFS_WAKE_CONFIG: begin
                next_prdata[7:0] = config_reg_one;
            end
            `OFS_WAKE_STATUS: begin
                next_prdata[15:0] = vector_addr;
                next_prdata[20:16] = state;
            end
            default: begin
                next_pslverr = 1'b1;
            end
        endcase
    end

    // read data captured in setup so it is a flop in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (apb_setup) begin
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= next_pslverr;
        end
    end

endmodule

// ### logic/wake_recovery_defs.svh
// constants for the wake, stop recovery and supply monitor block
// assumes a 16-bit APB byte address and a 100 MHz oscillator clock
// Functional notes
// [R1] reset pin low resets from wait or stop, fetch vector $FFFE
// [R2] irq falling edge in wait restarts cpu clock, vector $FFFA
// [R3] break in emulation wakes from wait or stop, vector $FFFC
// [R4] watchdog timeout in wait resets, vector $FFFE
// [R5] low supply reset wakes from wait or stop, vector $FFFE
// [R6] wait vectors: clock gen $FFF8, keyboard $FFE0, adc $FFDE, tbm $FFDC
// [R7] wait vectors: timer one overflow $FFF2, ch1 $FFF4, ch0 $FFF6
// [R8] timer two: ovf $FFEC, ch1 $FFEE, ch0 $FFF0, ch5-ch2 $FFCC-$FFD2
// [R9] spi transmit vector $FFE8, spi receive vector $FFEA
// [R10] serial vectors: transmit $FFE2, receive $FFE4, error $FFE6
// [R11] stop wakes only by pin, irq, keyboard edge, supply, break, tbm
// [R12] timebase rollover wakes from stop, vector $FFDC
// [R13] stop exit holds system clocks 4096 cycles on 12-bit counter
// [R14] short recovery select cuts the stop delay to 32 cycles
// [R15] software keeps short recovery clear with crystal unless osc kept
// [R16] monitor enabled out of reset, runs only while power down clear
// [R17] reset on low supply unless reset disable set, then poll only
// [R18] monitor works in stop only while monitor stop enable set
// [R19] power-on returns 3-V trip; 5-V select below trip resets at once
// [R20] low supply reset holds until supply rises above rising trip
// [R21] low supply reset also drives reset pin low
// [R22] status bit 7 flag: 1 below fall, 0 above rise, else holds
// [R23] timebase stays active in stop only while oscillator is kept
// [R24] comparator is two synchronised inputs: below fall, above rise
`ifndef WAKE_RECOVERY_DEFS_SVH
`define WAKE_RECOVERY_DEFS_SVH
`define OFS_SUPPLY_STATUS 16'hfe0c
`define OFS_WAKE_CONFIG 16'hfe10
`define OFS_WAKE_STATUS 16'hfe14
`define BIT_LOW_SUPPLY 7
`define BIT_PWR_DOWN 0
`define BIT_RST_DISABLE 1
`define BIT_STOP_ENABLE 2
`define BIT_TRIP_HIGH 3
`define BIT_SHORT_REC 4
`define BIT_OSC_KEEP 5
`define CONFIG_RESET 8'h00
`define VEC_RESET 16'hfffe
`define VEC_BREAK 16'hfffc
`define VEC_IRQ 16'hfffa
`define VEC_CLKGEN 16'hfff8
`define VEC_T1_CH0 16'hfff6
`define VEC_T1_CH1 16'hfff4
`define VEC_T1_OVF 16'hfff2
`define VEC_T2_CH0 16'hfff0
`define VEC_T2_CH1 16'hffee
`define VEC_T2_OVF 16'hffec
`define VEC_SPI_RX 16'hffea
`define VEC_SPI_TX 16'hffe8
`define VEC_SCI_ERR 16'hffe6
`define VEC_SCI_RX 16'hffe4
`define VEC_SCI_TX 16'hffe2
`define VEC_KBD 16'hffe0
`define VEC_ADC 16'hffde
`define VEC_TBM 16'hffdc
`define VEC_T2_CH2 16'hffd2
`define VEC_T2_CH3 16'hffd0
`define VEC_T2_CH4 16'hffce
`define VEC_T2_CH5 16'hffcc
`define PERIPH_COUNT 19
`define KBD_PIN_COUNT 8
`define RECOVERY_LONG_CYC 4096
`define RECOVERY_SHORT_CYC 32
`define RECOVERY_CNT_W 12
`define TRIP_SETTLE_CYC 3
`endif

// ### logic/wake_recovery_pkg.sv
// types for the wake, stop recovery and supply monitor block
// assumes nothing of its surroundings
package wake_recovery_pkg;
    // one-hot power states
    typedef enum logic [4:0] {
        ST_RUN = 5'h01,
        ST_WAIT = 5'h02,
        ST_STOP = 5'h04,
        ST_RECOVER = 5'h08,
        ST_HOLD = 5'h10
    } power_state_t;
endpackage
